//--- src/mmutlb_pkg.sv
// translation unit constants: register numbers, field positions, reset values
// assumes a single 100 MHz clock and a coprocessor register port on the core side
package mmutlb_pkg;

    // ======================================================================
    // coprocessor register numbers
    localparam logic [3:0] REG_TRANSLATION_CONTROL = 4'h1;
    localparam logic [3:0] REG_TABLE_BASE_POINTER = 4'h2;
    localparam logic [3:0] REG_DOMAIN_POLICY = 4'h3;
    localparam logic [3:0] REG_ABORT_CAUSE = 4'h5;
    localparam logic [3:0] REG_ABORT_LOCATION = 4'h6;
    localparam logic [3:0] REG_LOOKASIDE_MAINTENANCE = 4'h8;
    localparam logic [3:0] REG_PROCESS_ID = 4'hD;

    // maintenance operation selected by the op2 field of a register 8 write
    localparam logic [2:0] MAINT_INVALIDATE_ALL = 3'h0;
    localparam logic [2:0] MAINT_INVALIDATE_ENTRY = 3'h1;

    // ======================================================================
    // control register bit positions
    localparam int CTRL_TRANSLATE_BIT = 0;
    localparam int CTRL_ALIGN_BIT = 1;
    localparam int CTRL_SYSTEM_BIT = 8;
    localparam int CTRL_ROM_BIT = 9;
    localparam logic [31:0] CTRL_WRITABLE_MASK = 32'h0000_0303;

    // ======================================================================
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [17:0] TABLE_BASE_RESET = 18'h0_0000;
    localparam logic [31:0] DOMAIN_RESET = 32'h0000_0000;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [31:0] LOCATION_RESET = 32'h0000_0000;
    localparam logic [6:0] PROCESS_ID_RESET = 7'h00;

    // ======================================================================
    // fault type codes in the low nibble of the abort cause
    localparam logic [3:0] FAULT_ALIGNMENT = 4'h1;
    localparam logic [3:0] FAULT_TRANSLATION_SECTION = 4'h5;
    localparam logic [3:0] FAULT_TRANSLATION_PAGE = 4'h7;
    localparam logic [3:0] FAULT_DOMAIN_SECTION = 4'h9;
    localparam logic [3:0] FAULT_DOMAIN_PAGE = 4'hB;
    localparam logic [3:0] FAULT_PERMISSION_SECTION = 4'hD;
    localparam logic [3:0] FAULT_PERMISSION_PAGE = 4'hF;

    // ======================================================================
    // descriptor type codes and domain policy codes
    localparam logic [1:0] L1_INVALID = 2'h0;
    localparam logic [1:0] L1_COARSE = 2'h1;
    localparam logic [1:0] L1_SECTION = 2'h2;
    localparam logic [1:0] L1_FINE = 2'h3;
    localparam logic [1:0] L2_LARGE = 2'h1;
    localparam logic [1:0] L2_SMALL = 2'h2;
    localparam logic [1:0] L2_TINY = 2'h3;
    localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_MANAGER = 2'h3;

    typedef enum logic [1:0] {SZ_SECTION, SZ_LARGE, SZ_SMALL, SZ_TINY} mmutlb_size_type;

endpackage : mmutlb_pkg

//--- src/mmutlb_core.sv
// translation lookaside buffer, protection check, table walker and registers
// assumes the core holds a request until acc_done and walk memory answers wf_ack
`timescale 1ns/1ps

module mmutlb_core #(
    parameter int ENTRIES = 64
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // core access
    input wire logic req_valid,
    input wire logic [31:0] req_va,
    input wire logic req_write,
    input wire logic req_priv,
    input wire logic req_prefetch,
    input wire logic [1:0] req_size,
    input wire logic req_offchip,
    output logic acc_done,
    output logic acc_abort,
    output logic acc_offchip,
    output logic [31:0] acc_pa,
    output logic acc_cachable,
    output logic acc_bufferable,
    // coprocessor register port
    input wire logic cp_wr,
    input wire logic cp_rd,
    input wire logic [3:0] cp_reg,
    input wire logic [2:0] cp_op2,
    input wire logic [31:0] cp_wdata,
    output logic cp_rvalid,
    output logic [31:0] cp_rdata,
    // table walk memory port
    output logic wf_req,
    output logic [31:0] wf_addr,
    input wire logic wf_ack,
    input wire logic [31:0] wf_data
);

    localparam int IW = $clog2(ENTRIES);

    typedef enum logic [2:0] {ST_IDLE, ST_L1, ST_L2, ST_DONE} mmutlb_state_type;

    mmutlb_state_type state;
    logic [31:0] translation_control;
    logic [17:0] table_base_pointer;
    logic [31:0] domain_policy;
    logic [7:0] abort_cause;
    logic [31:0] abort_location;
    logic [6:0] process_id_register;

    // entry storage
    logic [ENTRIES-1:0] ent_valid;
    logic [21:0] ent_tag [ENTRIES];
    logic [21:0] ent_pa [ENTRIES];
    mmutlb_pkg::mmutlb_size_type ent_size [ENTRIES];
    logic [3:0] ent_dom [ENTRIES];
    logic [7:0] ent_ap [ENTRIES];
    logic [ENTRIES-1:0] ent_c;
    logic [ENTRIES-1:0] ent_b;
    logic [IW-1:0] fill_ptr;

    // walk scratch
    logic [3:0] walk_dom;
    logic walk_fine;

    // =====================================================================
    // helpers
    function automatic logic [31:0] low_mask(input mmutlb_pkg::mmutlb_size_type sz);
        unique case (sz)
            mmutlb_pkg::SZ_SECTION: low_mask = 32'h000F_FFFF;
            mmutlb_pkg::SZ_LARGE: low_mask = 32'h0000_FFFF;
            mmutlb_pkg::SZ_SMALL: low_mask = 32'h0000_0FFF;
            mmutlb_pkg::SZ_TINY: low_mask = 32'h0000_03FF;
        endcase
    endfunction : low_mask

    // access permission decode under the system and rom protection bits
    function automatic logic perm_ok(input logic [1:0] ap, input logic s, input logic r,
                                     input logic priv, input logic wr);
        unique case (ap)
            2'h0: perm_ok = !wr && ((s && !r && priv) || (!s && r));
            2'h1: perm_ok = priv;
            2'h2: perm_ok = priv || !wr;
            2'h3: perm_ok = 1'b1;
        endcase
    endfunction : perm_ok

    // =====================================================================
    // address relocation by process id
    logic [31:0] modified_virtual_address;
    assign modified_virtual_address = (req_va[31:25] == 7'h00) ? {process_id_register, req_va[24:0]} : req_va;

    // =====================================================================
    // lookup across every entry
    logic [ENTRIES-1:0] hit_vec;
    logic [ENTRIES-1:0] maint_vec;
    for (genvar gi = 0; gi < ENTRIES; gi++) begin : g_match
        logic [31:0] span;
        logic [21:0] keep;
        assign span = low_mask(ent_size[gi]);
        assign keep = ~span[31:10];
        assign hit_vec[gi] = ent_valid[gi] && (((ent_tag[gi] ^ modified_virtual_address[31:10]) & keep) == 22'h00_0000);
        assign maint_vec[gi] = ent_valid[gi] && (((ent_tag[gi] ^ cp_wdata[31:10]) & keep) == 22'h00_0000);
    end

    logic hit;
    logic [IW-1:0] hit_idx;
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (hit_vec[i] && !hit) begin
                hit = 1'b1;
                hit_idx = IW'(i);
            end
        end
    end

    // =====================================================================
    // protection decision for the hitting entry
    mmutlb_pkg::mmutlb_size_type h_size;
    logic [1:0] h_sub;
    logic [1:0] h_ap;
    logic [1:0] h_dpol;
    logic h_page;
    logic misaligned;
    logic [3:0] h_fault;
    logic h_deny;
    assign h_size = ent_size[hit_idx];
    always_comb begin
        unique case (h_size)
            mmutlb_pkg::SZ_LARGE: h_sub = modified_virtual_address[15:14];
            mmutlb_pkg::SZ_SMALL: h_sub = modified_virtual_address[11:10];
            default: h_sub = 2'h0;
        endcase
    end
    assign h_ap = ent_ap[hit_idx][2 * h_sub +: 2];
    assign h_dpol = domain_policy[2 * ent_dom[hit_idx] +: 2];
    assign h_page = (h_size != mmutlb_pkg::SZ_SECTION);
    assign misaligned = translation_control[mmutlb_pkg::CTRL_ALIGN_BIT] && !req_prefetch &&
                        ((req_size == 2'h2 && modified_virtual_address[1:0] != 2'h0) || (req_size == 2'h1 && modified_virtual_address[0]));

    always_comb begin
        h_deny = 1'b0;
        h_fault = mmutlb_pkg::FAULT_ALIGNMENT;
        if (misaligned) begin
            h_deny = 1'b1;
        end else if (h_dpol == mmutlb_pkg::DOM_NO_ACCESS || h_dpol == 2'h2) begin
            // abort outright; permission bits play no part
            h_deny = 1'b1;
            h_fault = h_page ? mmutlb_pkg::FAULT_DOMAIN_PAGE : mmutlb_pkg::FAULT_DOMAIN_SECTION;
        end else if (h_dpol == mmutlb_pkg::DOM_CLIENT) begin
            h_deny = !perm_ok(h_ap, translation_control[mmutlb_pkg::CTRL_SYSTEM_BIT],
                              translation_control[mmutlb_pkg::CTRL_ROM_BIT], req_priv, req_write);
            h_fault = h_page ? mmutlb_pkg::FAULT_PERMISSION_PAGE : mmutlb_pkg::FAULT_PERMISSION_SECTION;
        end
        // manager: allowed with no look at permission bits
    end

    // =====================================================================
    // walk decode
    logic [1:0] dtype;
    logic l1_fault;
    logic l2_fault;
    assign dtype = wf_data[1:0];
    assign l1_fault = (dtype == mmutlb_pkg::L1_INVALID);
    assign l2_fault = (dtype == 2'h0) || (dtype == mmutlb_pkg::L2_TINY && !walk_fine);

    logic translating;
    logic accept;
    logic walk_abort;
    assign translating = translation_control[mmutlb_pkg::CTRL_TRANSLATE_BIT];
    assign accept = (state == ST_IDLE) && req_valid;
    assign walk_abort = wf_ack && ((state == ST_L1 && l1_fault) || (state == ST_L2 && l2_fault));

    logic take_abort;
    logic [3:0] abort_dom;
    logic [3:0] abort_type;
    always_comb begin
        take_abort = 1'b0;
        abort_dom = ent_dom[hit_idx];
        abort_type = h_fault;
        if (walk_abort) begin
            take_abort = 1'b1;
            abort_dom = (state == ST_L1) ? 4'h0 : walk_dom;
            abort_type = (state == ST_L1) ? mmutlb_pkg::FAULT_TRANSLATION_SECTION
                                          : mmutlb_pkg::FAULT_TRANSLATION_PAGE;
        end else if (accept && (misaligned || (translating && hit && h_deny))) begin
            take_abort = 1'b1;
        end
    end

    // =====================================================================
    // access sequencing
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (accept && translating && !hit && !misaligned) begin
                        state <= ST_L1;
                    end else if (accept) begin
                        state <= ST_DONE;
                    end
                end
                ST_L1: begin
                    if (wf_ack) begin
                        if (l1_fault || dtype == mmutlb_pkg::L1_SECTION) begin
                            state <= l1_fault ? ST_DONE : ST_IDLE;
                        end else begin
                            state <= ST_L2;
                        end
                    end
                end
                ST_L2: begin
                    if (wf_ack) begin
                        // back to idle so the held access retries and hits
                        state <= l2_fault ? ST_DONE : ST_IDLE;
                    end
                end
                ST_DONE: state <= ST_IDLE;
            endcase
        end
    end

    // core answer; one idle cycle after done lets the core drop its request
    always_ff @(posedge mclk) begin
        if (srst) begin
            acc_done <= 1'b0;
            acc_abort <= 1'b0;
            acc_offchip <= 1'b0;
            acc_pa <= 32'h0000_0000;
            acc_cachable <= 1'b0;
            acc_bufferable <= 1'b0;
        end else begin
            acc_done <= 1'b0;
            acc_abort <= 1'b0;
            acc_offchip <= 1'b0;
            if (take_abort) begin
                acc_done <= 1'b1;
                acc_abort <= 1'b1;
            end else if (accept && !translating) begin
                acc_done <= 1'b1;
                acc_offchip <= 1'b1;
                acc_pa <= req_va;
                acc_cachable <= 1'b0;
                acc_bufferable <= 1'b0;
            end else if (accept && hit) begin
                acc_done <= 1'b1;
                acc_cachable <= ent_c[hit_idx];
                acc_bufferable <= ent_b[hit_idx];
                // uncachable regions always need the bus
                acc_offchip <= req_offchip || !ent_c[hit_idx];
                if (req_offchip || !ent_c[hit_idx]) begin
                    acc_pa <= ({ent_pa[hit_idx], 10'h000} & ~low_mask(h_size)) | (modified_virtual_address & low_mask(h_size));
                end
            end
        end
    end

    // =====================================================================
    // walk fetch port
    always_ff @(posedge mclk) begin
        if (srst) begin
            wf_req <= 1'b0;
            wf_addr <= 32'h0000_0000;
            walk_dom <= 4'h0;
            walk_fine <= 1'b0;
        end else begin
            if (state == ST_IDLE && accept && translating && !hit && !misaligned) begin
                wf_req <= 1'b1;
                wf_addr <= {table_base_pointer, modified_virtual_address[31:20], 2'b00};
            end else if (state == ST_L1 && wf_ack && (dtype == mmutlb_pkg::L1_COARSE || dtype == mmutlb_pkg::L1_FINE)) begin
                walk_dom <= wf_data[8:5];
                walk_fine <= (dtype == mmutlb_pkg::L1_FINE);
                wf_addr <= (dtype == mmutlb_pkg::L1_FINE) ? {wf_data[31:12], modified_virtual_address[19:10], 2'b00}
                                                         : {wf_data[31:10], modified_virtual_address[19:12], 2'b00};
            end else if (wf_ack) begin
                wf_req <= 1'b0;
            end
        end
    end

    // =====================================================================
    // entry fill and maintenance
    logic fill;
    assign fill = wf_ack && ((state == ST_L1 && dtype == mmutlb_pkg::L1_SECTION) || (state == ST_L2 && !l2_fault));

    always_ff @(posedge mclk) begin
        if (srst) begin
            ent_valid <= '0;
            fill_ptr <= '0;
        end else begin
            if (cp_wr && cp_reg == mmutlb_pkg::REG_LOOKASIDE_MAINTENANCE) begin
                if (cp_op2 == mmutlb_pkg::MAINT_INVALIDATE_ALL) begin
                    ent_valid <= '0;
                end else if (cp_op2 == mmutlb_pkg::MAINT_INVALIDATE_ENTRY) begin
                    ent_valid <= ent_valid & ~maint_vec;
                end
            end
            if (fill) begin
                ent_valid[fill_ptr] <= 1'b1;
                fill_ptr <= (fill_ptr == IW'(ENTRIES - 1)) ? '0 : fill_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (fill) begin
            ent_tag[fill_ptr] <= modified_virtual_address[31:10];
            if (state == ST_L1) begin
                ent_size[fill_ptr] <= mmutlb_pkg::SZ_SECTION;
                ent_pa[fill_ptr] <= {wf_data[31:20], 10'h000};
                ent_dom[fill_ptr] <= wf_data[8:5];
                ent_ap[fill_ptr] <= {4{wf_data[11:10]}};
            end else begin
                ent_dom[fill_ptr] <= walk_dom;
                unique case (dtype)
                    mmutlb_pkg::L2_LARGE: begin
                        ent_size[fill_ptr] <= mmutlb_pkg::SZ_LARGE;
                        ent_pa[fill_ptr] <= {wf_data[31:16], 6'h00};
                        ent_ap[fill_ptr] <= wf_data[11:4];
                    end
                    mmutlb_pkg::L2_SMALL: begin
                        ent_size[fill_ptr] <= mmutlb_pkg::SZ_SMALL;
                        ent_pa[fill_ptr] <= {wf_data[31:12], 2'h0};
                        ent_ap[fill_ptr] <= wf_data[11:4];
                    end
                    default: begin
                        ent_size[fill_ptr] <= mmutlb_pkg::SZ_TINY;
                        ent_pa[fill_ptr] <= wf_data[31:10];
                        ent_ap[fill_ptr] <= {4{wf_data[5:4]}};
                    end
                endcase
            end
            ent_c[fill_ptr] <= wf_data[3];
            ent_b[fill_ptr] <= wf_data[2];
        end
    end

    // =====================================================================
    // coprocessor registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            translation_control <= mmutlb_pkg::CTRL_RESET;
            table_base_pointer <= mmutlb_pkg::TABLE_BASE_RESET;
            domain_policy <= mmutlb_pkg::DOMAIN_RESET;
            process_id_register <= mmutlb_pkg::PROCESS_ID_RESET;
        end else if (cp_wr) begin
            unique case (cp_reg)
                mmutlb_pkg::REG_TRANSLATION_CONTROL:
                    translation_control <= cp_wdata & mmutlb_pkg::CTRL_WRITABLE_MASK;
                mmutlb_pkg::REG_TABLE_BASE_POINTER: table_base_pointer <= cp_wdata[31:14];
                mmutlb_pkg::REG_DOMAIN_POLICY: domain_policy <= cp_wdata;
                mmutlb_pkg::REG_PROCESS_ID: process_id_register <= cp_wdata[31:25];
                default: ;
            endcase
        end
    end

    // an abort in the same cycle as a software write wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            abort_cause <= mmutlb_pkg::CAUSE_RESET;
            abort_location <= mmutlb_pkg::LOCATION_RESET;
        end else if (take_abort) begin
            abort_cause <= {abort_dom, abort_type};
            abort_location <= modified_virtual_address;
        end else if (cp_wr && cp_reg == mmutlb_pkg::REG_ABORT_CAUSE) begin
            abort_cause <= cp_wdata[7:0];
        end else if (cp_wr && cp_reg == mmutlb_pkg::REG_ABORT_LOCATION) begin
            abort_location <= cp_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cp_rvalid <= 1'b0;
            cp_rdata <= 32'h0000_0000;
        end else begin
            cp_rvalid <= cp_rd;
            if (cp_rd) begin
                unique case (cp_reg)
                    mmutlb_pkg::REG_TRANSLATION_CONTROL: cp_rdata <= translation_control;
                    mmutlb_pkg::REG_TABLE_BASE_POINTER: cp_rdata <= {table_base_pointer, 14'h0000};
                    mmutlb_pkg::REG_DOMAIN_POLICY: cp_rdata <= domain_policy;
                    mmutlb_pkg::REG_ABORT_CAUSE: cp_rdata <= {24'h00_0000, abort_cause};
                    mmutlb_pkg::REG_ABORT_LOCATION: cp_rdata <= abort_location;
                    mmutlb_pkg::REG_PROCESS_ID: cp_rdata <= {process_id_register, 25'h000_0000};
                    // register 8 and unused numbers read zero
                    default: cp_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : mmutlb_core

//--- testbench/mmutlb_properties.sv
// checker: port-level timing of the translation unit
// assumes bind from tb onto mmutlb_core
`timescale 1ns/1ps
module mmutlb_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // core access
    input wire logic req_valid,
    input wire logic [31:0] req_va,
    input wire logic acc_done,
    input wire logic acc_abort,
    input wire logic acc_offchip,
    // registers and walk port
    input wire logic cp_rd,
    input wire logic [3:0] cp_reg,
    input wire logic cp_rvalid,
    input wire logic [31:0] cp_rdata,
    input wire logic wf_req,
    input wire logic [31:0] wf_addr,
    input wire logic wf_ack
);
    // ======================================================================
    // properties
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    AST_ABORT_DONE: assert property (acc_abort |-> acc_done && !acc_offchip)
        else $error("abort outside done");
    AST_OFF_DONE: assert property (acc_offchip |-> acc_done)
        else $error("address outside done");
    AST_DEAD_CYCLE: assert property (acc_done |=> !acc_done)
        else $error("done twice");
    AST_DONE_CAUSE: assert property (acc_done |-> $past(req_valid))
        else $error("done without request");
    AST_READ_ANSWER: assert property (cp_rvalid == $past(cp_rd))
        else $error("read answer timing");
    AST_MAINT_UNREADABLE: assert property (cp_rd && cp_reg == 4'h8 |=> cp_rdata == 32'h0)
        else $error("maintenance read nonzero");
    AST_BASE_ALIGNED: assert property (cp_rd && cp_reg == 4'h2 |=> cp_rdata[13:0] == 14'h0)
        else $error("base low bits set");
    AST_FETCH_HELD: assert property (wf_req && !wf_ack |=> wf_req && $stable(wf_addr))
        else $error("fetch dropped");
    AST_L1_INDEX: assert property ($rose(wf_req) && req_va[31:25] != 7'h0 |->
        wf_addr[13:0] == {req_va[31:20], 2'h0}) else $error("level one index");
    AST_WALK_BOUND: assert property ($rose(wf_req) |-> ##[1:64] acc_done)
        else $error("walk never ends");
endmodule : mmutlb_properties

//--- testbench/mmutlb_walk_mem.sv
// partner: table memory answering walk fetches
// assumes tb fills mem and sets lat
`timescale 1ns/1ps
module mmutlb_walk_mem (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // walk fetch port
    input wire logic wf_req,
    input wire logic [31:0] wf_addr,
    output logic wf_ack,
    output logic [31:0] wf_data
);
    logic [31:0] mem [bit [31:0]];
    int lat = 0, cnt = 0, fetches = 0;
    initial wf_data = 32'h0;
    always @(posedge mclk) begin
        wf_ack <= 1'b0;
        // between answers the data flips to its inverse each cycle, so the last descriptor returns every second cycle
        wf_data <= ~wf_data;
        if (srst)
            cnt <= 0;
        else if (wf_req && !wf_ack && cnt >= lat) begin
            wf_ack <= 1'b1;
            wf_data <= mem.exists(wf_addr) ? mem[wf_addr] : 32'h0;
            fetches <= fetches + 1;
            cnt <= 0;
        end else if (wf_req && !wf_ack)
            cnt <= cnt + 1;
    end
endmodule : mmutlb_walk_mem

//--- testbench/tb.sv
// bench: core accesses and register traffic, expectations built here
// assumes mmutlb_core default parameters
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_offchip = 1'b0;
    logic req_priv = 1'b1, req_prefetch = 1'b0;
    logic [1:0] req_size = 2'h2;
    logic cp_wr = 1'b0, cp_rd = 1'b0, acc_done, acc_abort, acc_offchip, acc_cachable;
    logic acc_bufferable, cp_rvalid, wf_req, wf_ack;
    logic [31:0] req_va = 32'h0, cp_wdata = 32'h0, acc_pa, cp_rdata, wf_addr, wf_data, b, va, p, pa, d;
    logic [3:0] cp_reg = 4'h0, r4;
    logic [2:0] cp_op2 = 3'h0;
    int errors = 0, comparisons = 0, k;
    mmutlb_core dut (.mclk, .srst, .req_valid, .req_va, .req_write, .req_priv, .req_prefetch,
        .req_size, .req_offchip, .acc_done, .acc_abort, .acc_offchip, .acc_pa, .acc_cachable,
        .acc_bufferable, .cp_wr, .cp_rd, .cp_reg, .cp_op2, .cp_wdata, .cp_rvalid, .cp_rdata, .wf_req,
        .wf_addr, .wf_ack, .wf_data);
    mmutlb_walk_mem mem_i (.mclk, .srst, .wf_req, .wf_addr, .wf_ack, .wf_data);
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("counts: %0d compared, %0d wrong", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // ======================================================================
    // port tasks
    task automatic cpw(logic [3:0] r, logic [31:0] w);
        @(posedge mclk);
        cp_wr <= 1'b1;
        cp_reg <= r;
        cp_wdata <= w;
        @(posedge mclk);
        cp_wr <= 1'b0;
    endtask : cpw
    task automatic cpr(logic [3:0] r, output logic [31:0] q);
        @(posedge mclk);
        cp_rd <= 1'b1;
        cp_reg <= r;
        @(posedge mclk);
        cp_rd <= 1'b0;
        #1 q = cp_rdata;
    endtask : cpr
    task automatic acc(logic [31:0] a, logic off);
        int i;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_va <= a;
        req_offchip <= off;
        req_write <= 1'($urandom_range(1));
        req_priv <= 1'($urandom_range(1));
        for (i = 0; i < 200 && acc_done !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 200) begin
            errors++;
            close_out();
        end
        r4 = {acc_abort, acc_offchip, acc_cachable, acc_bufferable};
        pa = acc_pa;
        // dead cycle after done ignores the request, drop it here
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask : acc
    // ======================================================================
    // scenarios
    initial begin
        void'($urandom(32'h91F8754C));
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        for (k = 0; k < 4; k++) begin
            cpr(4'h1 << (k % 4) | 4'(k / 2), d);
            chk(d, 32'h0);
        end
        cpr(4'h8, d);
        chk(d, 32'h0);
        b = $urandom();
        cpw(4'h2, b);
        cpr(4'h2, d);
        chk(d, {b[31:14], 14'h0});
        p = $urandom();
        cpw(4'h3, p);
        cpr(4'h3, d);
        chk(d, p);
        cpw(4'h1, 32'hFFFF_FFFC);
        cpr(4'h1, d);
        chk(d, 32'h300);
        $display("registers done");
        repeat (3) begin
            va = $urandom();
            acc(va, 1'b0);
            chk(r4, 4'h4);
            chk(pa, va);
        end
        $display("flat done");
        cpw(4'h3, 32'hC000);
        cpw(4'h1, 32'h301);
        va = {1'b1, 31'($urandom())};
        mem_i.lat = 3;
        mem_i.mem[{b[31:14], va[31:20], 2'h0}] = {p[31:20], 8'h0, 2'h3, 1'b0, 4'h7, 3'b110, 2'h2};
        acc(va, 1'b0);
        chk(r4, 4'h2);
        chk(mem_i.fetches, 1);
        va[19:0] = 20'($urandom());
        acc(va, 1'b1);
        chk(r4, 4'h6);
        chk(pa, {p[31:20], va[19:0]});
        chk(mem_i.fetches, 1);
        $display("section done");
        cpw(4'h1, 32'h303);
        acc({va[31:2], 2'h2}, 1'b1);
        req_prefetch <= 1'b1;
        chk(r4[3:2], 2'h2);
        cpr(4'h5, d);
        chk(d[3:0], 4'h1);
        acc({va[31:2], 2'h2}, 1'b1);
        req_prefetch <= 1'b0;
        chk(r4, 4'h6);
        cpw(4'h1, 32'h301);
        $display("alignment done");
        va ^= 32'h0010_0000;
        mem_i.mem[{b[31:14], va[31:20], 2'h0}] = {p[31:20], 8'h0, 2'h0, 1'b0, 4'h7, 3'b110, 2'h2};
        for (k = 0; k < 4; k++) begin
            cpw(4'h3, 32'(k) << 14);
            acc(va, 1'b1);
            chk(r4[3], k != 3);
            cpr(4'h5, d);
            if (k < 3)
                chk(d[7:0], {4'h7, k == 1 ? 4'hD : 4'h9});
            cpr(4'h6, d);
            if (k < 3)
                chk(d, va);
        end
        $display("domains done");
        va ^= 32'h0020_0000;
        acc(va, 1'b1);
        cpr(4'h5, d);
        chk(d[7:0], 8'h05);
        cpw(4'h8, 32'h0);
        k = mem_i.fetches;
        va ^= 32'h0020_0000;
        acc(va, 1'b1);
        chk(mem_i.fetches, k + 1);
        $display("maintenance done");
        va ^= 32'h0040_0000;
        va[11] = 1'b1;
        mem_i.mem[{b[31:14], va[31:20], 2'h0}] = {p[31:10], 1'b0, 4'h7, 3'b100, 2'h1};
        mem_i.mem[{p[31:10], va[19:12], 2'h0}] = {p[31:12], 8'hF0, 2'h2, 2'h2};
        cpw(4'h3, 32'h4000);
        k = mem_i.fetches;
        acc(va, 1'b1);
        chk(mem_i.fetches, k + 2);
        chk(r4, 4'h6);
        chk(pa, {p[31:12], va[11:0]});
        va[11] = 1'b0;
        acc(va, 1'b1);
        cp_op2 <= 3'h1;
        cpr(4'h5, d);
        chk({r4[3], d[7:0]}, 9'h17F);
        cpw(4'h8, va);
        k = mem_i.fetches;
        acc(va, 1'b1);
        chk(mem_i.fetches, k + 2);
        $display("pages done");
        close_out();
    end
endmodule : tb
bind mmutlb_core mmutlb_properties chk_i (.mclk, .srst, .req_valid, .req_va, .acc_done, .acc_abort,
    .acc_offchip, .cp_rd, .cp_reg, .cp_rvalid, .cp_rdata, .wf_req, .wf_addr, .wf_ack);
